/* File: core/cbd_defines.vh */
// Register offsets, field positions, reset values and state counts of the chained-block DMA engine
`ifndef CBD_DEFINES_VH
`define CBD_DEFINES_VH
// ==========================================
// Register byte offsets
`define CBD_OFF_STATUS 8'h00
`define CBD_OFF_MODE 8'h04
`define CBD_OFF_CHAIN_BASE 8'h08
`define CBD_OFF_CUR_PTR 8'h0C
`define CBD_OFF_END_PTR 8'h10
`define CBD_OFF_RX_BUF_LEN 8'h14
`define CBD_OFF_BUF_ADDR 8'h18
`define CBD_OFF_BYTE_COUNT 8'h1C
`define CBD_OFF_FRAME_CNT 8'h20
// ==========================================
// Status register bits
`define CBD_ST_ERROR 0
`define CBD_ST_ENABLE 1
`define CBD_ST_FRAME_END 2
`define CBD_ST_BUSY 3
// ==========================================
// Mode register bits
`define CBD_MD_TRANSFER_MODE 0
`define CBD_MD_MULTI_FRAME 1
`define CBD_MD_RX_DIR 2
`define CBD_MD_ERR_IE 3
`define CBD_MD_FE_IE 4
`define CBD_MD_CPU_MODE1 5
`define CBD_MODE_W 6
// ==========================================
// Descriptor layout, byte offsets inside an 8-byte descriptor
`define CBD_DSC_NEXT 3'h0
`define CBD_DSC_BUF_LO 3'h2
`define CBD_DSC_STAT_BUF_HI 3'h4
`define CBD_DSC_LEN 3'h6
`define CBD_DSC_EOM 0
`define CBD_DSC_EOT 1
// ==========================================
// Reset values
`define CBD_RST_MODE 6'h00
`define CBD_RST_BYTE 8'h00
`define CBD_RST_HALF 16'h0000
`define CBD_RST_ADDR 24'h00_0000
`define CBD_FCT_MAX 4'hF
`define CBD_FCT_ZERO 4'h0
// ==========================================
// Inserted state counts, one state per pclk cycle
`define CBD_SETUP_STD 6'h14
`define CBD_SETUP_CPU1 6'h20
`define CBD_SWITCH_MID 6'h01
`define CBD_SWITCH_END 6'h05
`endif

/* File: core/cbd_state_timer.v */
// Down counter that marks the end of a run of inserted states
`timescale 1ns/1ps
module cbd_state_timer (
  input wire pclk,
  input wire presetn,
  input wire start,
  input wire [5:0] load,
  output reg done
);
  reg [5:0] count_r;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_r <= 6'h00;
      done <= 1'b0;
    end else begin
      done <= (count_r == 6'h01) & ~start;
      if (start) begin
        count_r <= load;
      end else if (count_r != 6'h00) begin
        count_r <= count_r - 6'h01;
      end
    end
  end
endmodule // cbd_state_timer

/* File: core/cbd_chain_dma.v */
// Chained-block DMA engine: descriptor walk, transmit and receive data paths, APB registers
`timescale 1ns/1ps
`include "cbd_defines.vh"
module cbd_chain_dma #(
  parameter CHANNEL_ID = 0
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  output reg mem_req,
  output reg mem_we,
  output reg mem_word,
  output reg [23:0] mem_addr,
  output reg [15:0] mem_wdata,
  input wire [15:0] mem_rdata,
  input wire mem_ack,
  input wire ser_bitsync,
  input wire ser_req,
  input wire ser_word,
  input wire [15:0] ser_rx_data,
  input wire ser_frame_end,
  input wire [7:0] ser_frame_status,
  output reg ser_ack,
  output reg [15:0] ser_tx_data,
  output reg ser_tx_word,
  output reg ser_tx_eom,
  output reg frame_end_interrupt,
  output reg error_interrupt
);
  // ==========================================
  // States
  localparam S_IDLE = 4'd0;
  localparam S_ARM = 4'd1;
  localparam S_SETUP = 4'd2;
  localparam S_FETCH = 4'd3;
  localparam S_READY = 4'd4;
  localparam S_RDDATA = 4'd5;
  localparam S_WRDATA = 4'd6;
  localparam S_WBLEN = 4'd7;
  localparam S_WBST = 4'd8;
  localparam S_SWITCH = 4'd9;

  // Only channels 0 and 2 may run the receive chain
  localparam RX_OK = (CHANNEL_ID == 0) || (CHANNEL_ID == 2);

  reg [3:0] state_r;
  reg enable_r;
  reg err_flag_r;
  reg fe_flag_r;
  reg [`CBD_MODE_W-1:0] mode_r;
  reg [7:0] chain_base_r;
  reg [15:0] cur_ptr_r;
  reg [15:0] end_ptr_r;
  reg [15:0] rx_len_r;
  reg [23:0] buf_addr_r;
  reg [15:0] byte_cnt_r;
  reg [3:0] fct_r;
  reg [15:0] next_link_r;
  reg [7:0] dsc_stat_r;
  reg [1:0] fetch_idx_r;
  reg first_r;
  reg frame_done_r;
  reg stop_pend_r;
  reg [15:0] rx_data_r;
  reg rx_word_r;
  reg rx_fe_r;
  reg tmr_start_r;
  reg [5:0] tmr_load_r;
  wire tmr_done;

  wire rx_dir = mode_r[`CBD_MD_RX_DIR];
  wire multi = mode_r[`CBD_MD_MULTI_FRAME];
  wire apb_wr = psel & penable & pready & pwrite;
  wire sw_set_en = apb_wr & (paddr == `CBD_OFF_STATUS) & pwdata[`CBD_ST_ENABLE];
  wire fct_ack = apb_wr & (paddr == `CBD_OFF_FRAME_CNT);
  // Current pointer is owned by software only while the engine is halted
  wire sw_cur_wr = apb_wr & (paddr == `CBD_OFF_CUR_PTR) & (state_r == S_IDLE);

  // ==========================================
  // Helpers
  // 24-bit descriptor address; the offset wraps inside the chain base region
  function [23:0] dsc_addr;
    input [7:0] base;
    input [15:0] ptr;
    input [2:0] off;
    begin
      dsc_addr = {base, ptr + {13'h0000, off}};
    end
  endfunction

  function [15:0] step;
    input word;
    begin
      step = word ? 16'h0002 : 16'h0001;
    end
  endfunction

  // Word moves only when at least two bytes remain, otherwise a byte
  wire tx_word = ser_word & (byte_cnt_r > 16'h0001);
  wire rx_word_ok = rx_word_r & (byte_cnt_r > 16'h0001);
  wire [15:0] rx_step = step(rx_word_ok);

  cbd_state_timer u_timer (
    .pclk(pclk),
    .presetn(presetn),
    .start(tmr_start_r),
    .load(tmr_load_r),
    .done(tmr_done)
  );

  // ==========================================
  // APB slave: one access cycle, registered read data
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= psel & ~penable;
      pslverr <= 1'b0;
      if (psel & ~penable) begin
        prdata <= 32'h0000_0000;
        case (paddr)
          `CBD_OFF_STATUS: prdata[3:0] <= {state_r != S_IDLE, fe_flag_r, enable_r, err_flag_r};
          `CBD_OFF_MODE: prdata[`CBD_MODE_W-1:0] <= mode_r;
          `CBD_OFF_CHAIN_BASE: prdata[7:0] <= chain_base_r;
          `CBD_OFF_CUR_PTR: prdata[15:0] <= cur_ptr_r;
          `CBD_OFF_END_PTR: prdata[15:0] <= end_ptr_r;
          `CBD_OFF_RX_BUF_LEN: prdata[15:0] <= rx_len_r;
          `CBD_OFF_BUF_ADDR: prdata[23:0] <= buf_addr_r;
          `CBD_OFF_BYTE_COUNT: prdata[15:0] <= byte_cnt_r;
          `CBD_OFF_FRAME_CNT: prdata[3:0] <= fct_r;
          default: pslverr <= 1'b1;
        endcase
      end
    end
  end

  // ==========================================
  // Software-owned configuration
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_r <= `CBD_RST_MODE;
      chain_base_r <= `CBD_RST_BYTE;
      end_ptr_r <= `CBD_RST_HALF;
      rx_len_r <= `CBD_RST_HALF;
    end else if (apb_wr) begin
      case (paddr)
        `CBD_OFF_MODE: mode_r <= pwdata[`CBD_MODE_W-1:0];
        `CBD_OFF_CHAIN_BASE: chain_base_r <= pwdata[7:0];
        // Accepted at any time so buffers can be handed over on the fly
        `CBD_OFF_END_PTR: end_ptr_r <= pwdata[15:0];
        `CBD_OFF_RX_BUF_LEN: rx_len_r <= pwdata[15:0];
        default: ;
      endcase
    end
  end

  // ==========================================
  // Engine
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= S_IDLE;
      enable_r <= 1'b0;
      err_flag_r <= 1'b0;
      fe_flag_r <= 1'b0;
      cur_ptr_r <= `CBD_RST_HALF;
      buf_addr_r <= `CBD_RST_ADDR;
      byte_cnt_r <= `CBD_RST_HALF;
      fct_r <= `CBD_FCT_ZERO;
      next_link_r <= `CBD_RST_HALF;
      dsc_stat_r <= `CBD_RST_BYTE;
      fetch_idx_r <= 2'd0;
      first_r <= 1'b0;
      frame_done_r <= 1'b0;
      stop_pend_r <= 1'b0;
      rx_data_r <= `CBD_RST_HALF;
      rx_word_r <= 1'b0;
      rx_fe_r <= 1'b0;
      tmr_start_r <= 1'b0;
      tmr_load_r <= 6'h00;
      mem_req <= 1'b0;
      mem_we <= 1'b0;
      mem_word <= 1'b0;
      mem_addr <= `CBD_RST_ADDR;
      mem_wdata <= `CBD_RST_HALF;
      ser_ack <= 1'b0;
      ser_tx_data <= `CBD_RST_HALF;
      ser_tx_word <= 1'b0;
      ser_tx_eom <= 1'b0;
      frame_end_interrupt <= 1'b0;
      error_interrupt <= 1'b0;
    end else begin
      tmr_start_r <= 1'b0;
      ser_ack <= 1'b0;
      frame_end_interrupt <= 1'b0;
      error_interrupt <= 1'b0;
      // Sticky flags: a hardware set in the same cycle beats the write-one clear
      if (apb_wr & (paddr == `CBD_OFF_STATUS)) begin
        enable_r <= pwdata[`CBD_ST_ENABLE];
        if (pwdata[`CBD_ST_ERROR]) err_flag_r <= 1'b0;
        if (pwdata[`CBD_ST_FRAME_END]) fe_flag_r <= 1'b0;
      end
      if (sw_cur_wr) cur_ptr_r <= pwdata[15:0];
      if (fct_ack & (fct_r != `CBD_FCT_ZERO)) fct_r <= fct_r - 4'h1;
      case (state_r)
        S_IDLE: begin
          first_r <= 1'b1;
          // Halted on unsupported framing or a receive chain on a wrong channel
          if (enable_r & ser_bitsync & (~rx_dir | RX_OK)) state_r <= S_ARM;
        end
        S_ARM: begin
          if (~enable_r | ~ser_bitsync) begin
            state_r <= S_IDLE;
          end else if (ser_req) begin
            if (cur_ptr_r == end_ptr_r) begin
              // Out of buffers: no data moves for this request
              enable_r <= sw_set_en;
              err_flag_r <= 1'b1;
              error_interrupt <= mode_r[`CBD_MD_ERR_IE];
              state_r <= S_IDLE;
            end else begin
              fetch_idx_r <= 2'd0;
              if (first_r & ~rx_dir) begin
                tmr_start_r <= 1'b1;
                tmr_load_r <= mode_r[`CBD_MD_CPU_MODE1] ? `CBD_SETUP_CPU1 : `CBD_SETUP_STD;
                state_r <= S_SETUP;
              end else begin
                state_r <= S_FETCH;
              end
            end
          end
        end
        S_SETUP: begin
          if (tmr_done) state_r <= S_FETCH;
        end
        S_FETCH: begin
          if (~mem_req) begin
            mem_req <= 1'b1;
            mem_we <= 1'b0;
            mem_word <= 1'b1;
            mem_addr <= dsc_addr(chain_base_r, cur_ptr_r, {fetch_idx_r, 1'b0});
          end else if (mem_ack) begin
            mem_req <= 1'b0;
            fetch_idx_r <= fetch_idx_r + 2'd1;
            case (fetch_idx_r)
              2'd0: next_link_r <= mem_rdata;
              2'd1: buf_addr_r[15:0] <= mem_rdata;
              2'd2: begin
                buf_addr_r[23:16] <= mem_rdata[7:0];
                dsc_stat_r <= mem_rdata[15:8];
                if (rx_dir) begin
                  byte_cnt_r <= rx_len_r;
                  first_r <= 1'b0;
                  state_r <= S_READY;
                end
              end
              default: begin
                byte_cnt_r <= mem_rdata;
                first_r <= 1'b0;
                state_r <= S_READY;
              end
            endcase
          end
        end
        S_READY: begin
          if (~enable_r) begin
            state_r <= S_IDLE;
          end else if (~rx_dir & (byte_cnt_r == 16'h0000)) begin
            // Transmit buffer drained: END_OF_MESSAGE closes the frame, END_OF_TRANSMISSION closes the chain
            cur_ptr_r <= next_link_r;
            frame_done_r <= dsc_stat_r[`CBD_DSC_EOM];
            stop_pend_r <= dsc_stat_r[`CBD_DSC_EOT];
            tmr_start_r <= 1'b1;
            tmr_load_r <= dsc_stat_r[`CBD_DSC_EOM] ? `CBD_SWITCH_END : `CBD_SWITCH_MID;
            state_r <= S_SWITCH;
          end else if (ser_req & ~ser_ack) begin
            // A request still standing in the ack cycle is the one just served
            if (rx_dir) begin
              rx_data_r <= ser_rx_data;
              rx_word_r <= ser_word;
              rx_fe_r <= ser_frame_end;
              state_r <= S_WRDATA;
            end else begin
              mem_req <= 1'b1;
              mem_we <= 1'b0;
              mem_word <= tx_word;
              mem_addr <= buf_addr_r;
              state_r <= S_RDDATA;
            end
          end
        end
        S_RDDATA: begin
          if (mem_ack) begin
            mem_req <= 1'b0;
            ser_ack <= 1'b1;
            ser_tx_data <= mem_rdata;
            ser_tx_word <= mem_word;
            ser_tx_eom <= (byte_cnt_r == step(mem_word)) & dsc_stat_r[`CBD_DSC_EOM];
            buf_addr_r <= buf_addr_r + {8'h00, step(mem_word)};
            byte_cnt_r <= byte_cnt_r - step(mem_word);
            state_r <= S_READY;
          end
        end
        S_WRDATA: begin
          if (~mem_req) begin
            mem_req <= 1'b1;
            mem_we <= 1'b1;
            mem_word <= rx_word_ok;
            mem_addr <= buf_addr_r;
            mem_wdata <= rx_data_r;
          end else if (mem_ack) begin
            mem_req <= 1'b0;
            ser_ack <= 1'b1;
            buf_addr_r <= buf_addr_r + {8'h00, rx_step};
            byte_cnt_r <= byte_cnt_r - rx_step;
            // Frame end switches at once; a full buffer switches too
            if (rx_fe_r | (byte_cnt_r == rx_step)) state_r <= S_WBLEN;
            else state_r <= S_READY;
          end
        end
        S_WBLEN: begin
          if (~mem_req) begin
            mem_req <= 1'b1;
            mem_we <= 1'b1;
            mem_word <= 1'b1;
            mem_addr <= dsc_addr(chain_base_r, cur_ptr_r, `CBD_DSC_LEN);
            mem_wdata <= rx_len_r - byte_cnt_r;
          end else if (mem_ack) begin
            mem_req <= 1'b0;
            if (rx_fe_r) begin
              state_r <= S_WBST;
            end else begin
              cur_ptr_r <= next_link_r;
              state_r <= S_ARM;
            end
          end
        end
        S_WBST: begin
          if (~mem_req) begin
            mem_req <= 1'b1;
            mem_we <= 1'b1;
            mem_word <= 1'b1;
            mem_addr <= dsc_addr(chain_base_r, cur_ptr_r, `CBD_DSC_STAT_BUF_HI);
            mem_wdata <= {ser_frame_status, buf_addr_r[23:16]};
          end else if (mem_ack) begin
            mem_req <= 1'b0;
            cur_ptr_r <= next_link_r;
            frame_done_r <= 1'b1;
            stop_pend_r <= 1'b0;
            state_r <= S_SWITCH;
            tmr_start_r <= 1'b1;
            tmr_load_r <= `CBD_SWITCH_MID;
          end
        end
        S_SWITCH: begin
          if (tmr_done) begin
            frame_done_r <= 1'b0;
            stop_pend_r <= 1'b0;
            if (frame_done_r) begin
              fe_flag_r <= 1'b1;
              frame_end_interrupt <= mode_r[`CBD_MD_FE_IE];
            end
            if (frame_done_r & (fct_r == `CBD_FCT_MAX)) begin
              // Counter overflow: the frame just finished is the last one
              fct_r <= `CBD_FCT_ZERO;
              err_flag_r <= 1'b1;
              error_interrupt <= mode_r[`CBD_MD_ERR_IE];
              enable_r <= sw_set_en;
              state_r <= S_IDLE;
            end else if ((frame_done_r & ~multi) | stop_pend_r) begin
              if (frame_done_r) fct_r <= fct_r + 4'h1 - {3'h0, fct_ack & (fct_r != `CBD_FCT_ZERO)};
              enable_r <= sw_set_en;
              state_r <= S_IDLE;
            end else begin
              if (frame_done_r) fct_r <= fct_r + 4'h1 - {3'h0, fct_ack & (fct_r != `CBD_FCT_ZERO)};
              state_r <= S_ARM;
            end
          end
        end
        default: state_r <= S_IDLE;
      endcase
    end
  end
endmodule // cbd_chain_dma

/* File: testbench/cbd_chain_dma_properties.sv */
// Port-level checker for the chained-block DMA engine, bound to its top module
`timescale 1ns/1ps
module cbd_chain_dma_properties (
  input logic pclk,
  input logic presetn,
  input logic psel,
  input logic penable,
  input logic pready,
  input logic pslverr,
  input logic mem_req,
  input logic mem_ack,
  input logic mem_we,
  input logic [23:0] mem_addr,
  input logic ser_bitsync,
  input logic ser_ack,
  input logic frame_end_interrupt,
  input logic error_interrupt
);
  // ==========================================
  // Shared clocking
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence apb_setup;
    psel && !penable;
  endsequence
  sequence mem_waiting;
    mem_req && !mem_ack;
  endsequence
  // ==========================================
  // Register bus
  apb_zero_wait_a: assert property (apb_setup |=> pready) else $error("pready late");
  pready_pulse_a: assert property (pready |=> !pready) else $error("pready held");
  slverr_gated_a: assert property (pslverr |-> pready) else $error("pslverr alone");
  // ==========================================
  // Memory port
  mem_hold_a: assert property (mem_waiting |=> mem_req && $stable(mem_addr) && $stable(mem_we))
    else $error("memory request changed while waiting");
  mem_drop_a: assert property (mem_req && mem_ack |=> !mem_req) else $error("memory request kept");
  // ==========================================
  // Serial side and events
  ack_after_mem_a: assert property ($rose(ser_ack) |-> $past(mem_ack)) else $error("ack without memory");
  ack_pulse_a: assert property (ser_ack |=> !ser_ack) else $error("serial ack held");
  no_framing_a: assert property (!ser_bitsync [*3] |-> !ser_ack) else $error("ack without framing");
  fe_pulse_a: assert property (frame_end_interrupt |=> !frame_end_interrupt) else $error("frame irq held");
  err_noack_a: assert property (error_interrupt |-> !ser_ack ##1 !error_interrupt)
    else $error("error irq with ack");
  cover property (frame_end_interrupt);
endmodule // cbd_chain_dma_properties

bind cbd_chain_dma cbd_chain_dma_properties u_cbd_chain_dma_properties (
  .pclk(pclk),
  .presetn(presetn),
  .psel(psel),
  .penable(penable),
  .pready(pready),
  .pslverr(pslverr),
  .mem_req(mem_req),
  .mem_ack(mem_ack),
  .mem_we(mem_we),
  .mem_addr(mem_addr),
  .ser_bitsync(ser_bitsync),
  .ser_ack(ser_ack),
  .frame_end_interrupt(frame_end_interrupt),
  .error_interrupt(error_interrupt)
);

/* File: testbench/cbd_mem_model.sv */
// Behavioural system memory on the engine's memory port, answering fast and slow in turn
`timescale 1ns/1ps
module cbd_mem_model (
  input logic pclk,
  input logic presetn,
  input logic mem_req,
  input logic mem_we,
  input logic mem_word,
  input logic [23:0] mem_addr,
  input logic [15:0] mem_wdata,
  output logic [15:0] mem_rdata,
  output logic mem_ack
);
  // Full 24-bit byte space, so descriptors anywhere in one 64 KB region work
  logic [7:0] mem [logic [23:0]];
  logic [1:0] wait_r;
  logic slow_r;
  function automatic logic [7:0] rd8(input logic [23:0] a);
    return mem.exists(a) ? mem[a] : 8'hA5;
  endfunction
  task automatic poke16(input logic [23:0] a, input logic [15:0] d);
    mem[a] = d[7:0];
    mem[a + 24'h00_0001] = d[15:8];
  endtask
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_ack <= 1'b0;
      wait_r <= 2'h0;
      slow_r <= 1'b0;
      mem_rdata <= 16'h0000;
    end else if (mem_ack || !mem_req) begin
      // Released bus inverts its value every cycle
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
    end else if (wait_r == (slow_r ? 2'h2 : 2'h0)) begin
      mem_ack <= 1'b1;
      wait_r <= 2'h0;
      slow_r <= ~slow_r;
      if (mem_we) begin
        mem[mem_addr] = mem_wdata[7:0];
        if (mem_word) begin
          mem[mem_addr + 24'h00_0001] = mem_wdata[15:8];
        end
      end
      mem_rdata <= {mem_word ? rd8(mem_addr + 24'h00_0001) : ~mem_rdata[15:8], rd8(mem_addr)};
    end else begin
      wait_r <= wait_r + 2'h1;
    end
  end
endmodule // cbd_mem_model

/* File: testbench/cbd_chain_dma_tb_top.sv */
// Self-checking bench for the chained-block DMA engine
`timescale 1ns/1ps
`include "cbd_defines.vh"
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin fails++; $display("mismatch %s exp %h got %h", n, e, g); end end
module cbd_chain_dma_tb_top;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rdv;
  logic pready, pslverr, rde, mem_req, mem_we, mem_word, mem_ack, ser_ack, ser_tx_word, ser_tx_eom;
  logic [23:0] mem_addr;
  logic [15:0] mem_wdata, mem_rdata, ser_tx_data;
  logic ser_bitsync, ser_req, ser_word, ser_frame_end;
  logic [15:0] ser_rx_data;
  logic [7:0] ser_frame_status;
  logic frame_end_interrupt, error_interrupt;
  int fails = 0, checks = 0, fe_n = 0, er_n = 0, mreq_n = 0, cyc;
  always #5 pclk = ~pclk;
  always @(posedge pclk) begin
    fe_n <= fe_n + (frame_end_interrupt === 1'b1);
    er_n <= er_n + (error_interrupt === 1'b1);
    mreq_n <= mreq_n + (mem_req === 1'b1);
  end
  cbd_chain_dma u_cbd_chain_dma (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .mem_req(mem_req), .mem_we(mem_we), .mem_word(mem_word), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_rdata(mem_rdata), .mem_ack(mem_ack), .ser_bitsync(ser_bitsync), .ser_req(ser_req),
    .ser_word(ser_word), .ser_rx_data(ser_rx_data), .ser_frame_end(ser_frame_end),
    .ser_frame_status(ser_frame_status), .ser_ack(ser_ack), .ser_tx_data(ser_tx_data),
    .ser_tx_word(ser_tx_word), .ser_tx_eom(ser_tx_eom), .frame_end_interrupt(frame_end_interrupt),
    .error_interrupt(error_interrupt));
  cbd_mem_model u_cbd_mem_model (.pclk(pclk), .presetn(presetn), .mem_req(mem_req), .mem_we(mem_we),
    .mem_word(mem_word), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ack(mem_ack));
  // ==========================================
  // Bus and serial drivers, entered just after a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 50) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 50) fails++;
    rdv = prdata;
    rde = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic ser(input logic w, input logic [15:0] d, input logic fe);
    ser_req <= 1'b1;
    ser_word <= w;
    ser_rx_data <= d;
    ser_frame_end <= fe;
    cyc = 0;
    @(posedge pclk);
    while (ser_ack !== 1'b1 && cyc < 120) begin
      @(posedge pclk);
      cyc++;
    end
    ser_req <= 1'b0;
    ser_rx_data <= ~d;
    @(posedge pclk);
  endtask
  // ==========================================
  // Scenarios
  task automatic t_regs;
    apb(0, `CBD_OFF_STATUS, 0);
    `CHK("status reset", 32'h0000_0000, rdv)
    apb(0, 8'h40, 0);
    `CHK("unmapped err", 1'b1, rde)
    apb(1, `CBD_OFF_BUF_ADDR, 32'h00FF_FFFF);
    apb(0, `CBD_OFF_BUF_ADDR, 0);
    `CHK("buf addr ro", 32'h0000_0000, rdv)
    apb(1, `CBD_OFF_MODE, 32'h0000_003F);
    apb(0, `CBD_OFF_MODE, 0);
    `CHK("mode rw", 32'h0000_003F, rdv)
    ser(1'b0, 16'h0011, 1'b0);
    `CHK("idle no ack", 120, cyc)
    `CHK("idle no mem", 0, mreq_n)
    $display("test regs done");
  endtask
  task automatic t_rx;
    u_cbd_mem_model.poke16(24'h01_0100, 16'h0108);
    u_cbd_mem_model.poke16(24'h01_0102, 16'h0000);
    u_cbd_mem_model.poke16(24'h01_0104, 16'h0002);
    apb(1, `CBD_OFF_MODE, 32'h0000_001C);
    apb(1, `CBD_OFF_CHAIN_BASE, 32'h0000_0001);
    apb(1, `CBD_OFF_CUR_PTR, 32'h0000_0100);
    apb(1, `CBD_OFF_END_PTR, 32'h0000_0110);
    apb(1, `CBD_OFF_RX_BUF_LEN, 32'h0000_0004);
    apb(1, `CBD_OFF_STATUS, 32'h0000_0002);
    ser_bitsync <= 1'b0;
    ser(1'b1, 16'h0077, 1'b0);
    `CHK("no framing ack", 120, cyc)
    ser_bitsync <= 1'b1;
    ser_frame_status <= 8'h5A;
    ser(1'b0, 16'h0011, 1'b0);
    apb(0, `CBD_OFF_BUF_ADDR, 0);
    `CHK("addr plus 1", 32'h0002_0001, rdv)
    apb(0, `CBD_OFF_BYTE_COUNT, 0);
    `CHK("count minus 1", 32'h0000_0003, rdv)
    ser(1'b1, 16'h3322, 1'b0);
    apb(0, `CBD_OFF_BUF_ADDR, 0);
    `CHK("addr plus 2", 32'h0002_0003, rdv)
    ser(1'b1, 16'h0044, 1'b1);
    // Descriptor write-back and the buffer switch finish after the last ack
    repeat (20) @(posedge pclk);
    `CHK("data bytes", 32'h4433_2211, {u_cbd_mem_model.rd8(24'h02_0003), u_cbd_mem_model.rd8(24'h02_0002),
      u_cbd_mem_model.rd8(24'h02_0001), u_cbd_mem_model.rd8(24'h02_0000)})
    `CHK("desc length", 16'h0004, {u_cbd_mem_model.rd8(24'h01_0107), u_cbd_mem_model.rd8(24'h01_0106)})
    `CHK("desc status", 8'h5A, u_cbd_mem_model.rd8(24'h01_0105))
    apb(0, `CBD_OFF_CUR_PTR, 0);
    `CHK("cur advanced", 32'h0000_0108, rdv)
    apb(0, `CBD_OFF_STATUS, 0);
    `CHK("single stop", 2'b10, rdv[2:1])
    `CHK("frame irq", 1, fe_n)
    $display("test rx done");
  endtask
  task automatic t_err;
    apb(1, `CBD_OFF_END_PTR, 32'h0000_0108);
    apb(1, `CBD_OFF_STATUS, 32'h0000_0006);
    ser(1'b0, 16'h0055, 1'b0);
    `CHK("end no ack", 120, cyc)
    `CHK("error irq", 1, er_n)
    apb(0, `CBD_OFF_STATUS, 0);
    `CHK("error stop", 2'b01, rdv[1:0])
    apb(1, `CBD_OFF_STATUS, 32'h0000_0001);
    apb(0, `CBD_OFF_STATUS, 0);
    `CHK("error cleared", 1'b0, rdv[0])
    $display("test err done");
  endtask
  task automatic t_tx;
    u_cbd_mem_model.poke16(24'h01_0110, 16'h0118);
    u_cbd_mem_model.poke16(24'h01_0112, 16'h0000);
    u_cbd_mem_model.poke16(24'h01_0114, 16'h0303);
    u_cbd_mem_model.poke16(24'h01_0116, 16'h0002);
    u_cbd_mem_model.poke16(24'h03_0000, 16'hBEAA);
    apb(1, `CBD_OFF_MODE, 32'h0000_0011);
    apb(1, `CBD_OFF_CUR_PTR, 32'h0000_0110);
    apb(1, `CBD_OFF_END_PTR, 32'h0000_0118);
    apb(1, `CBD_OFF_STATUS, 32'h0000_0002);
    ser(1'b0, 16'h0000, 1'b0);
    `CHK("setup wait", 1'b1, cyc >= 24 && cyc < 120)
    `CHK("tx byte 0", 8'hAA, ser_tx_data[7:0])
    `CHK("tx byte lane", 1'b0, ser_tx_word)
    `CHK("tx eom early", 1'b0, ser_tx_eom)
    ser(1'b0, 16'h0000, 1'b0);
    `CHK("tx byte 1", 8'hBE, ser_tx_data[7:0])
    `CHK("tx eom last", 1'b1, ser_tx_eom)
    repeat (12) @(posedge pclk);
    apb(0, `CBD_OFF_CUR_PTR, 0);
    `CHK("tx cur next", 32'h0000_0118, rdv)
    apb(0, `CBD_OFF_STATUS, 0);
    `CHK("tx eot stop", 1'b0, rdv[1])
    `CHK("tx frame irq", 2, fe_n)
    $display("test tx done");
  endtask
  task automatic t_multi;
    u_cbd_mem_model.poke16(24'h01_0118, 16'h0120);
    u_cbd_mem_model.poke16(24'h01_011A, 16'h0010);
    u_cbd_mem_model.poke16(24'h01_011C, 16'h0103);
    u_cbd_mem_model.poke16(24'h01_011E, 16'h0001);
    u_cbd_mem_model.poke16(24'h01_0120, 16'h0128);
    u_cbd_mem_model.poke16(24'h01_0122, 16'h0011);
    u_cbd_mem_model.poke16(24'h01_0124, 16'h0203);
    u_cbd_mem_model.poke16(24'h01_0126, 16'h0001);
    u_cbd_mem_model.poke16(24'h03_0010, 16'hD2C1);
    apb(1, `CBD_OFF_MODE, 32'h0000_0013);
    apb(1, `CBD_OFF_END_PTR, 32'h0000_0120);
    apb(1, `CBD_OFF_STATUS, 32'h0000_0002);
    ser(1'b1, 16'h0000, 1'b0);
    `CHK("multi byte 0", 9'h1C1, {ser_tx_eom, ser_tx_data[7:0]})
    repeat (12) @(posedge pclk);
    apb(0, `CBD_OFF_STATUS, 0);
    `CHK("multi stays on", 1'b1, rdv[1])
    apb(1, `CBD_OFF_END_PTR, 32'h0000_0128);
    ser(1'b1, 16'h0000, 1'b0);
    `CHK("added buffer", 8'hD2, ser_tx_data[7:0])
    repeat (12) @(posedge pclk);
    apb(0, `CBD_OFF_STATUS, 0);
    `CHK("multi eot stop", 1'b0, rdv[1])
    apb(0, `CBD_OFF_CUR_PTR, 0);
    `CHK("multi cur", 32'h0000_0128, rdv)
    apb(0, `CBD_OFF_FRAME_CNT, 0);
    `CHK("frame count", 32'h0000_0003, rdv)
    `CHK("multi frame irq", 3, fe_n)
    $display("test multi done");
  endtask
  // ==========================================
  // Verdict
  task automatic final_report;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    ser_bitsync <= 1'b1;
    ser_req <= 1'b0;
    ser_word <= 1'b0;
    ser_frame_end <= 1'b0;
    ser_rx_data <= 16'h0000;
    ser_frame_status <= 8'h00;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs;
    t_rx;
    t_err;
    t_tx;
    t_multi;
    final_report;
  end
  // All five scenarios need well under 2000 cycles
  initial begin
    repeat (8000) @(posedge pclk);
    fails++;
    final_report;
  end
endmodule // cbd_chain_dma_tb_top
